// file: acrf_register_file.v
// working register file with alternate contexts, context control and bus slave
`timescale 1ns/10ps
`include "acrf_defs.vh"

// What this block does
// - sixteen 16-bit working registers, each usable as data, pointer or offset.
// - register 15 is the stack pointer for interrupts and calls.
// - four alternate sets copy registers 0 to 14 only, never the stack pointer.
// - a 3-bit field per alternate set ties it to priority level 1 to 7 for entry.
// - alternate set contents persist between handler runs.
// - a swap instruction selects an alternate set by hand, regardless of level.
// - a read-only status word shows the active set and the last hand-picked set.
// - bus accesses to registers 0 to 14 reach the active context copy.
// - every programmer-visible register is readable over the bus; all but the status word and loop start words are writable.
// - the program counter is 23 bits wide.
// - the loop start high and low words are read-only; writes change nothing.
module acrf_register_file #(
   parameter NUM_ALT = 4,
   parameter DW      = 16,
   parameter PCW     = 23
) (
   input  wire                    clk,
   input  wire                    reset,
   // axi4-lite slave
   input  wire [`ACRF_ADDR_W-1:0] s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output wire                    s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output wire                    s_axi_wready,
   output wire [1:0]              s_axi_bresp,
   output wire                    s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`ACRF_ADDR_W-1:0] s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output wire                    s_axi_arready,
   output wire [31:0]             s_axi_rdata,
   output wire [1:0]              s_axi_rresp,
   output wire                    s_axi_rvalid,
   input  wire                    s_axi_rready,
   // execution side operand ports
   input  wire [3:0]              cpuRdIdxA,
   output wire [DW-1:0]           cpuRdDataA,
   input  wire [3:0]              cpuRdIdxB,
   output wire [DW-1:0]           cpuRdDataB,
   input  wire                    cpuWrEn,
   input  wire [3:0]              cpuWrIdx,
   input  wire [DW-1:0]           cpuWrData,
   output wire [DW-1:0]           stackPointer,
   // context control
   input  wire                    intEnter,
   input  wire [2:0]              interruptPriorityLevel,
   input  wire                    ctxRestore,
   input  wire [2:0]              ctxRestoreIdx,
   input  wire                    contextSwapInstruction,
   input  wire [2:0]              ctxSwapIdx,
   output wire [2:0]              currentContextIndex,
   output wire [2:0]              manualContextIndex,
   // program counter and loop start
   input  wire                    pcLoad,
   input  wire [PCW-1:0]          pcLoadValue,
   input  wire                    pcAdvance,
   output wire [PCW-1:0]          pcOut,
   input  wire                    loopStartLoad,
   input  wire [PCW-1:0]          loopStartValue
);

   localparam CFGW          = NUM_ALT * `ACRF_CFG_FW;
   localparam [2:0] MAX_CTX = NUM_ALT;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // set tied to a level; 0 when none, lowest set wins on a duplicate
   function [2:0] setForLevel;
      input [CFGW-1:0] cfg;
      input [2:0]      lvl;
      integer          k;
      begin
         setForLevel = 3'h0;
         for (k = NUM_ALT; k >= 1; k = k - 1)
            if (lvl != 3'h0 && cfg[(k-1)*`ACRF_CFG_FW +: `ACRF_CFG_FW] == lvl)
               setForLevel = k[2:0];
      end
   endfunction

   // byte-lane merge of a bus write into a narrower register
   function [31:0] strbMerge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      b;
      begin
         strbMerge = old;
         for (b = 0; b < 4; b = b + 1)
            if (strb[b])
               strbMerge[b*8 +: 8] = nw[b*8 +: 8];
      end
   endfunction

   // working register window covers offsets 0x00 to 0x3c
   function isWreg;
      input [`ACRF_ADDR_W-1:0] a;
      begin
         isWreg = (a <= `ACRF_OFF_WREG15);
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [2:0]      curCtx_r;
   reg [2:0]      curCtx_nxt;
   reg [2:0]      manCtx_r;
   reg [2:0]      manCtx_nxt;
   reg [CFGW-1:0] altCfg_r;
   reg [PCW-1:0]  pc_r;
   reg [PCW-1:0]  loopStart_r;
   reg            bvalid_r;
   reg [1:0]      bresp_r;
   reg            rvalid_r;
   reg [1:0]      rresp_r;
   reg [31:0]     rdata_r;

   wire           wrGo;
   wire           rdGo;
   wire [3:0]     busIdx;
   wire [DW-1:0]  busWordRd;
   wire           bankWrEn;
   wire [3:0]     bankWrIdx;
   wire [DW-1:0]  bankWrData;
   wire [31:0]    wrMerged;
   wire [31:0]    cfgMerged;
   wire [31:0]    pcMerged;
   wire           wrIsAddr;
   wire           wrKnown;
   reg  [31:0]    rdWord;
   reg            rdKnown;

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   // address and data taken together; a core write in the same cycle stalls the bus
   assign wrGo          = s_axi_awvalid && s_axi_wvalid && !bvalid_r && !cpuWrEn;
   assign s_axi_awready = wrGo;
   assign s_axi_wready  = wrGo;
   // reads yield to a write taken in the same cycle since they share a bank port
   assign rdGo          = s_axi_arvalid && !rvalid_r && !wrGo;
   assign s_axi_arready = rdGo;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   assign busIdx = wrGo ? s_axi_awaddr[5:2] : s_axi_araddr[5:2];

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   // core write port has priority over the bus
   assign wrIsAddr   = isWreg(s_axi_awaddr);
   assign wrMerged   = strbMerge({16'h0000, busWordRd}, s_axi_wdata, s_axi_wstrb);
   assign bankWrEn   = cpuWrEn || (wrGo && wrIsAddr);
   assign bankWrIdx  = cpuWrEn ? cpuWrIdx : s_axi_awaddr[5:2];
   assign bankWrData = cpuWrEn ? cpuWrData : wrMerged[DW-1:0];
   // merged words are cut back to the register width where they are stored
   assign cfgMerged  = strbMerge({{(32-CFGW){1'b0}}, altCfg_r}, s_axi_wdata, s_axi_wstrb);
   assign pcMerged   = strbMerge({{(32-PCW){1'b0}}, pc_r}, s_axi_wdata, s_axi_wstrb);

   acrf_bank #(
      .NUM_ALT (NUM_ALT),
      .DW      (DW)
   ) u_bank (
      .clk     (clk),
      .reset   (reset),
      .ctx     (curCtx_r),
      .rdIdxA  (cpuRdIdxA),
      .rdDataA (cpuRdDataA),
      .rdIdxB  (cpuRdIdxB),
      .rdDataB (cpuRdDataB),
      .rdIdxC  (busIdx),
      .rdDataC (busWordRd),
      .wrEn    (bankWrEn),
      .wrIdx   (bankWrIdx),
      .wrData  (bankWrData),
      .spData  (stackPointer)
   );

   // ----------------------------------------------------------------
   // context selection
   // ----------------------------------------------------------------
   // return restores first, then interrupt entry, then a manual swap;
   // an out-of-range set index is ignored rather than aliasing storage
   always @* begin
      curCtx_nxt = curCtx_r;
      manCtx_nxt = manCtx_r;
      if (ctxRestore && ctxRestoreIdx <= MAX_CTX) begin
         curCtx_nxt = ctxRestoreIdx;
      end else if (intEnter && setForLevel(altCfg_r, interruptPriorityLevel) != 3'h0) begin
         curCtx_nxt = setForLevel(altCfg_r, interruptPriorityLevel);
      end else if (contextSwapInstruction && ctxSwapIdx <= MAX_CTX) begin
         curCtx_nxt = ctxSwapIdx;
         manCtx_nxt = ctxSwapIdx;
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         curCtx_r <= `ACRF_CTX_RST;
         manCtx_r <= `ACRF_CTX_RST;
      end else begin
         curCtx_r <= curCtx_nxt;
         manCtx_r <= manCtx_nxt;
      end
   end

   assign currentContextIndex = curCtx_r;
   assign manualContextIndex  = manCtx_r;

   // ----------------------------------------------------------------
   // configuration, program counter, loop start
   // ----------------------------------------------------------------
   // priority fields are software owned
   always @(posedge clk or posedge reset) begin
      if (reset)
         altCfg_r <= `ACRF_CFG_RST;
      else if (wrGo && s_axi_awaddr == `ACRF_OFF_ALTCFG)
         altCfg_r <= cfgMerged[CFGW-1:0];
   end

   // core load beats a bus write, which beats sequential advance
   always @(posedge clk or posedge reset) begin
      if (reset)
         pc_r <= `ACRF_PC_RST;
      else if (pcLoad)
         pc_r <= pcLoadValue;
      else if (wrGo && s_axi_awaddr == `ACRF_OFF_PC)
         pc_r <= pcMerged[PCW-1:0];
      else if (pcAdvance)
         pc_r <= pc_r + `ACRF_PC_STEP;
   end

   assign pcOut = pc_r;

   // loop start only changes from the loop hardware, never from the bus
   always @(posedge clk or posedge reset) begin
      if (reset)
         loopStart_r <= `ACRF_LS_RST;
      else if (loopStartLoad)
         loopStart_r <= loopStartValue;
   end

   // ----------------------------------------------------------------
   // write response
   // ----------------------------------------------------------------
   // read-only words accept the write silently; unknown offsets get an error
   assign wrKnown = wrIsAddr
                 || s_axi_awaddr == `ACRF_OFF_CTXSTAT
                 || s_axi_awaddr == `ACRF_OFF_ALTCFG
                 || s_axi_awaddr == `ACRF_OFF_PC
                 || s_axi_awaddr == `ACRF_OFF_LSH
                 || s_axi_awaddr == `ACRF_OFF_LSL;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `ACRF_RESP_OKAY;
      end else if (wrGo) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wrKnown ? `ACRF_RESP_OKAY : `ACRF_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // status word is built from live state, so a read sees the latest switch
   always @* begin
      rdWord  = 32'h00000000;
      rdKnown = 1'b1;
      if (isWreg(s_axi_araddr)) begin
         rdWord[DW-1:0] = busWordRd;
      end else begin
         case (s_axi_araddr)
            `ACRF_OFF_CTXSTAT: begin
               rdWord[`ACRF_CUR_LSB +: 3] = curCtx_r;
               rdWord[`ACRF_MAN_LSB +: 3] = manCtx_r;
            end
            `ACRF_OFF_ALTCFG: begin
               rdWord[CFGW-1:0] = altCfg_r;
            end
            `ACRF_OFF_PC: begin
               rdWord[PCW-1:0] = pc_r;
            end
            `ACRF_OFF_LSH: begin
               rdWord[`ACRF_LSH_W-1:0] = loopStart_r[PCW-1:16];
            end
            `ACRF_OFF_LSL: begin
               rdWord[15:0] = loopStart_r[15:0];
            end
            default: begin
               rdKnown = 1'b0;
            end
         endcase
      end
   end

   // data is captured at the address edge and held until rready
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rvalid_r <= 1'b0;
         rresp_r  <= `ACRF_RESP_OKAY;
         rdata_r  <= 32'h00000000;
      end else if (rdGo) begin
         rvalid_r <= 1'b1;
         rresp_r  <= rdKnown ? `ACRF_RESP_OKAY : `ACRF_RESP_SLVERR;
         rdata_r  <= rdWord;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule

// file: acrf_defs.vh
// register offsets, field positions, reset values and constants of the context register file
`ifndef ACRF_DEFS_VH
`define ACRF_DEFS_VH

// ----------------------------------------------------------------
// bus map (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define ACRF_ADDR_W      8
`define ACRF_OFF_WREG0   8'h00
`define ACRF_OFF_WREG15  8'h3c
`define ACRF_OFF_CTXSTAT 8'h40
`define ACRF_OFF_ALTCFG  8'h44
`define ACRF_OFF_PC      8'h48
`define ACRF_OFF_LSH     8'h4c
`define ACRF_OFF_LSL     8'h50

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACRF_CUR_LSB     0
`define ACRF_MAN_LSB     8
`define ACRF_CFG_FW      3
`define ACRF_LSH_W       7
`define ACRF_SP_IDX      4'hf

// ----------------------------------------------------------------
// reset values and fixed steps
// ----------------------------------------------------------------
`define ACRF_CTX_RST     3'h0
`define ACRF_CFG_RST     12'h000
`define ACRF_PC_RST      23'h000000
`define ACRF_LS_RST      23'h000000
`define ACRF_PC_STEP     23'h000002
`define ACRF_WORD_RST    16'h0000

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define ACRF_RESP_OKAY   2'h0
`define ACRF_RESP_SLVERR 2'h2

`endif

// file: acrf_bank.v
// storage array: primary working set plus alternate sets, three read ports, one write port
`timescale 1ns/10ps
`include "acrf_defs.vh"

module acrf_bank #(
   parameter NUM_ALT = 4,
   parameter DW      = 16
) (
   input  wire          clk,
   input  wire          reset,
   input  wire [2:0]    ctx,
   input  wire [3:0]    rdIdxA,
   output wire [DW-1:0] rdDataA,
   input  wire [3:0]    rdIdxB,
   output wire [DW-1:0] rdDataB,
   input  wire [3:0]    rdIdxC,
   output wire [DW-1:0] rdDataC,
   input  wire          wrEn,
   input  wire [3:0]    wrIdx,
   input  wire [DW-1:0] wrData,
   output wire [DW-1:0] spData
);

   localparam DEPTH = (NUM_ALT + 1) * 16;

   reg [DW-1:0] mem [0:DEPTH-1];
   integer      i;

   // ----------------------------------------------------------------
   // physical index
   // ----------------------------------------------------------------
   // stack pointer never shadowed: index 15 always maps to the primary copy
   function [6:0] physIdx;
      input [2:0] c;
      input [3:0] r;
      begin
         if (r == `ACRF_SP_IDX)
            physIdx = {3'h0, r};
         else
            physIdx = {c, r};
      end
   endfunction

   // ----------------------------------------------------------------
   // array
   // ----------------------------------------------------------------
   // alternate copies are only ever written by their own context, so they persist
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= `ACRF_WORD_RST;
      end else if (wrEn) begin
         mem[physIdx(ctx, wrIdx)] <= wrData;
      end
   end

   // read ports follow the active context
   assign rdDataA = mem[physIdx(ctx, rdIdxA)];
   assign rdDataB = mem[physIdx(ctx, rdIdxB)];
   assign rdDataC = mem[physIdx(ctx, rdIdxC)];
   assign spData  = mem[15];

endmodule

// file: acrf_register_file_assertions.sv
// concurrent checks on the ports of the context register file
`timescale 1ns/10ps
`include "acrf_defs.vh"
module acrf_register_file_assertions #(
   parameter DW  = 16,
   parameter PCW = 23
) (
   input wire           clk,
   input wire           reset,
   input wire           s_axi_awvalid,
   input wire           s_axi_awready,
   input wire           s_axi_wvalid,
   input wire           s_axi_wready,
   input wire           s_axi_bvalid,
   input wire           s_axi_arvalid,
   input wire           s_axi_arready,
   input wire [31:0]    s_axi_rdata,
   input wire           s_axi_rvalid,
   input wire           s_axi_rready,
   input wire           cpuWrEn,
   input wire [DW-1:0]  stackPointer,
   input wire           intEnter,
   input wire [2:0]     interruptPriorityLevel,
   input wire           ctxRestore,
   input wire           contextSwapInstruction,
   input wire [2:0]     ctxSwapIdx,
   input wire [2:0]     currentContextIndex,
   input wire [2:0]     manualContextIndex,
   input wire           pcLoad,
   input wire [PCW-1:0] pcLoadValue,
   input wire           pcAdvance,
   input wire [PCW-1:0] pcOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // a bus write taken this edge; swap with no higher-priority context request
   wire wrGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire hand = contextSwapInstruction && !ctxRestore && !intEnter;
   sequence s_wrTake;
      wrGo;
   endsequence
   sequence s_rdTake;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_sp_common: assert property (hand && !cpuWrEn && !wrGo |=> $stable(stackPointer))
      else $error("stack pointer moved on a set swap");
   a_swap_select: assert property (hand && ctxSwapIdx < 3'h5 |=>
      currentContextIndex == $past(ctxSwapIdx) && manualContextIndex == $past(ctxSwapIdx))
      else $error("swap did not select the requested set");
   a_swap_refuse: assert property (hand && ctxSwapIdx > 3'h4 |=>
      $stable(currentContextIndex) && $stable(manualContextIndex))
      else $error("out of range swap changed the context");
   a_manual_only: assert property (!contextSwapInstruction |=> $stable(manualContextIndex))
      else $error("manual index changed without a swap");
   a_level_zero: assert property (intEnter && interruptPriorityLevel == 3'h0 &&
      !ctxRestore && !contextSwapInstruction |=> $stable(currentContextIndex))
      else $error("level zero entry changed the context");
   a_ctx_hold: assert property (!intEnter && !ctxRestore && !contextSwapInstruction |=>
      $stable(currentContextIndex))
      else $error("context changed with no request");
   a_reset_state: assert property ($fell(reset) |->
      currentContextIndex == 3'h0 && manualContextIndex == 3'h0)
      else $error("context not primary after reset");
   a_write_answer: assert property (s_wrTake |=> s_axi_bvalid && !s_axi_awready)
      else $error("write taken twice back to back");
   a_read_answer: assert property (s_rdTake |=> s_axi_rvalid)
      else $error("read taken but no answer");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");
   a_pc_step: assert property (pcAdvance && !pcLoad && !wrGo |=>
      pcOut == $past(pcOut) + `ACRF_PC_STEP)
      else $error("program counter step wrong");
   a_pc_load: assert property (pcLoad |=> pcOut == $past(pcLoadValue))
      else $error("program counter load wrong");
endmodule

// file: acrf_core_model.sv
// execution unit and interrupt controller model driving the core side
`timescale 1ns/10ps
module acrf_core_model (
   input  wire        clk,
   output reg  [3:0]  cpuRdIdxA,
   output reg  [3:0]  cpuRdIdxB,
   output reg         cpuWrEn,
   output reg  [3:0]  cpuWrIdx,
   output reg  [15:0] cpuWrData,
   output reg         intEnter,
   output reg  [2:0]  interruptPriorityLevel,
   output reg         ctxRestore,
   output reg  [2:0]  ctxRestoreIdx,
   output reg         contextSwapInstruction,
   output reg  [2:0]  ctxSwapIdx,
   output reg         pcLoad,
   output reg  [22:0] pcLoadValue,
   output reg         pcAdvance,
   output reg         loopStartLoad,
   output reg  [22:0] loopStartValue
);
   // everything quiet at time zero
   initial begin
      {cpuRdIdxA, cpuRdIdxB, cpuWrEn, cpuWrIdx, cpuWrData, intEnter, interruptPriorityLevel,
       ctxRestore, ctxRestoreIdx, contextSwapInstruction, ctxSwapIdx, pcLoad, pcLoadValue,
       pcAdvance, loopStartLoad, loopStartValue} = 0;
   end
   // one-cycle request of kind k; qualifiers inverted after so stale samples cannot pass
   task go(input [3:0] k, input [22:0] v);
      begin
         @(posedge clk);
         case (k)
            0: {contextSwapInstruction, ctxSwapIdx} <= {1'b1, v[2:0]};
            1: {intEnter, interruptPriorityLevel} <= {1'b1, v[2:0]};
            2: {ctxRestore, ctxRestoreIdx} <= {1'b1, v[2:0]};
            3: {pcLoad, pcLoadValue} <= {1'b1, v};
            4: pcAdvance <= 1'b1;
            5: {loopStartLoad, loopStartValue} <= {1'b1, v};
            6: {cpuWrEn, cpuWrIdx, cpuWrData} <= {1'b1, v[19:0]};
            default: {cpuRdIdxA, cpuRdIdxB} <= {v[3:0], 4'hf};
         endcase
         @(posedge clk);
         {cpuWrEn, intEnter, ctxRestore, contextSwapInstruction, pcLoad, pcAdvance,
          loopStartLoad} <= 7'h00;
         {ctxSwapIdx, interruptPriorityLevel, ctxRestoreIdx, cpuWrIdx, cpuWrData} <=
            ~{ctxSwapIdx, interruptPriorityLevel, ctxRestoreIdx, cpuWrIdx, cpuWrData};
      end
   endtask
endmodule

// file: test_alternate_context_register_file.sv
// self-checking bench for the context register file
`timescale 1ns/10ps
`include "acrf_defs.vh"
module test_alternate_context_register_file;
   reg         clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg  [7:0]  s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata, w;
   reg  [3:0]  s_axi_wstrb;
   reg  [15:0] v [0:15];
   reg  [33:0] rq [$];
   reg  [33:0] bq [$];
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        cpuWrEn, intEnter, ctxRestore, contextSwapInstruction, pcLoad, pcAdvance;
   wire        loopStartLoad;
   wire [3:0]  cpuRdIdxA, cpuRdIdxB, cpuWrIdx;
   wire [15:0] cpuRdDataA, cpuRdDataB, cpuWrData, stackPointer;
   wire [2:0]  interruptPriorityLevel, ctxRestoreIdx, ctxSwapIdx;
   wire [2:0]  currentContextIndex, manualContextIndex;
   wire [22:0] pcLoadValue, pcOut, loopStartValue;
   integer     errors, samples_checked, seed, cyc, i, s;
   localparam [1:0]  OK = `ACRF_RESP_OKAY;
   localparam [7:0]  ST = `ACRF_OFF_CTXSTAT;
   localparam [14:0] LV = 15'o50673;
   localparam [14:0] EX = 15'o22241;

   acrf_register_file u_acrf_register_file (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpuRdIdxA, .cpuRdDataA, .cpuRdIdxB,
      .cpuRdDataB, .cpuWrEn, .cpuWrIdx, .cpuWrData, .stackPointer, .intEnter,
      .interruptPriorityLevel, .ctxRestore, .ctxRestoreIdx, .contextSwapInstruction,
      .ctxSwapIdx, .currentContextIndex, .manualContextIndex, .pcLoad, .pcLoadValue,
      .pcAdvance, .pcOut, .loopStartLoad, .loopStartValue);
   acrf_core_model u_acrf_core_model (.clk, .cpuRdIdxA, .cpuRdIdxB, .cpuWrEn, .cpuWrIdx,
      .cpuWrData, .intEnter, .interruptPriorityLevel, .ctxRestore, .ctxRestoreIdx,
      .contextSwapInstruction, .ctxSwapIdx, .pcLoad, .pcLoadValue, .pcAdvance,
      .loopStartLoad, .loopStartValue);

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task check(input [33:0] seen, input [33:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("errors %0d samples_checked %0d", errors, samples_checked);
         if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task go(input [3:0] k, input [22:0] x);
      u_acrf_core_model.go(k, x);
   endtask
   // write with random response stall; address and data inverted once released
   task wr(input [7:0] a, input [31:0] d, input [1:0] r);
      begin
         @(posedge clk);
         bq.push_back({r, 32'h0});
         {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
         do @(posedge clk); while (s_axi_awready !== 1'b1);
         {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {~a, ~d, 2'b00};
         repeat ({$random(seed)} % 3) @(posedge clk);
         s_axi_bready <= 1'b1;
         do @(posedge clk); while (s_axi_bvalid !== 1'b1);
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [1:0] r, input [31:0] d);
      begin
         @(posedge clk);
         rq.push_back({r, d});
         {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
         do @(posedge clk); while (s_axi_arready !== 1'b1);
         {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
         repeat ({$random(seed)} % 3) @(posedge clk);
         s_axi_rready <= 1'b1;
         do @(posedge clk); while (s_axi_rvalid !== 1'b1);
         s_axi_rready <= 1'b0;
      end
   endtask

   // clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // response monitor and hang guard
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         check({s_axi_bresp, 32'h0}, bq.pop_front());
      if (cyc == 20000) begin
         errors = errors + 1;
         give_verdict;
      end
   end
   // main sequence
   initial begin
      {reset, seed, errors, samples_checked, cyc} = {1'b1, 32'd58, 96'd0};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rd(ST, OK, 32'h0);
      for (i = 0; i < 16; i = i + 1) begin
         w = $random(seed);
         v[i] = w[15:0];
         wr({i[5:0], 2'b00}, w, OK);
      end
      for (i = 0; i < 16; i = i + 1)
         rd({i[5:0], 2'b00}, OK, {16'h0, v[i]});
      rd(8'h60, `ACRF_RESP_SLVERR, 32'h0);
      wr(8'h60, w, `ACRF_RESP_SLVERR);
      for (s = 1; s < 5; s = s + 1) begin
         go(0, s[22:0]);
         wr(8'h0c, {16'h0, {4{s[3:0]}}}, OK);
      end
      go(0, 23'h7);
      rd(ST, OK, 32'h0404);
      for (s = 4; s >= 0; s = s - 1) begin
         go(0, s[22:0]);
         go(7, 23'h3);
         #1;
         check(cpuRdDataA, s ? {4{s[3:0]}} : v[3]);
         check(cpuRdDataB, v[15]);
         check(stackPointer, v[15]);
         rd(8'h0c, OK, {16'h0, s ? {4{s[3:0]}} : v[3]});
      end
      wr(`ACRF_OFF_ALTCFG, 32'h0e2b, OK);
      rd(`ACRF_OFF_ALTCFG, OK, 32'h0e2b);
      for (i = 4; i >= 0; i = i - 1) begin
         go(1, {20'h0, LV[i*3 +: 3]});
         rd(ST, OK, {29'h0, EX[i*3 +: 3]});
      end
      go(0, 23'h3);
      go(1, 23'h5);
      go(2, 23'h7);
      wr(ST, 32'hffffffff, OK);
      rd(ST, OK, 32'h0302);
      w = $random(seed);
      go(6, {3'h0, 4'h3, w[15:0]});
      rd(8'h0c, OK, {16'h0, w[15:0]});
      go(2, 23'h0);
      rd(8'h0c, OK, {16'h0, v[3]});
      s_axi_wstrb <= 4'h1;
      wr(8'h0c, 32'h0, OK);
      s_axi_wstrb <= 4'hf;
      rd(8'h0c, OK, {16'h0, v[3][15:8], 8'h00});
      w = $random(seed);
      go(3, w[22:0]);
      go(4, 23'h0);
      rd(`ACRF_OFF_PC, OK, {9'h0, w[22:0] + `ACRF_PC_STEP});
      wr(`ACRF_OFF_PC, ~w, OK);
      rd(`ACRF_OFF_PC, OK, {9'h0, ~w[22:0]});
      go(5, w[22:0]);
      wr(`ACRF_OFF_LSH, ~w, OK);
      wr(`ACRF_OFF_LSL, ~w, OK);
      rd(`ACRF_OFF_LSH, OK, {25'h0, w[22:16]});
      rd(`ACRF_OFF_LSL, OK, {16'h0, w[15:0]});
      // second reset in mid-run must bring back the primary set
      go(0, 23'h3);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(ST, OK, 32'h0);
      rd(8'h00, OK, 32'h0);
      repeat (4) @(posedge clk);
      if (rq.size() != 0 || bq.size() != 0)
         errors = errors + 1;
      give_verdict;
   end
endmodule

// checker attached to every instance of the register file
bind acrf_register_file acrf_register_file_assertions #(.DW(DW), .PCW(PCW)) u_chk (.clk,
   .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .cpuWrEn,
   .stackPointer,
   .intEnter, .interruptPriorityLevel, .ctxRestore, .contextSwapInstruction, .ctxSwapIdx,
   .currentContextIndex, .manualContextIndex, .pcLoad, .pcLoadValue, .pcAdvance, .pcOut);
